// >>> verilog/fph_pkg.sv
// Shared constants, encodings and carrier types of the coprocessor host sequencer
package fph_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses on the Wishbone port)
   // ------------------------------------------------------------
   localparam logic [7:0] ADR_CMD = 8'h00;
   localparam logic [7:0] ADR_DATA = 8'h04;
   localparam logic [7:0] ADR_AUX = 8'h08;
   // Identification value of this unit; the value is arbitrary
   localparam logic [3:0] OWN_ID = 4'h5;
   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   localparam logic [1:0] FMT_S = 2'h0;
   localparam logic [1:0] FMT_D = 2'h1;
   localparam logic [1:0] FMT_X = 2'h2;
   localparam logic [1:0] FMT_I = 2'h3;
   localparam logic [3:0] OP_MOV = 4'h0;
   localparam logic [3:0] OP_NEG = 4'h1;
   localparam logic [3:0] OP_ABS = 4'h2;
   localparam logic [3:0] OP_CMP = 4'h3;
   localparam logic [1:0] KIND_BCAST = 2'h0;
   localparam logic [1:0] KIND_FETCH = 2'h1;
   localparam logic [1:0] KIND_STAT = 2'h2;
   localparam logic [1:0] KIND_WRITE = 2'h3;
   // ------------------------------------------------------------
   // Auxiliary status fields and reset values
   // ------------------------------------------------------------
   localparam int AUX_RA = 0;
   localparam int AUX_BUSY = 1;
   localparam int AUX_EXC = 2;
   localparam int AUX_STK = 3;
   localparam int AUX_MSK = 8;
   localparam int AUX_CC = 13;
   localparam int AUX_MODE = 16;
   localparam logic [4:0] MASK_RST = 5'h00;
   // ------------------------------------------------------------
   // Format geometry
   // ------------------------------------------------------------
   localparam logic [5:0] FW_S = 6'h17;
   localparam logic [5:0] FW_D = 6'h34;
   localparam logic [17:0] EMAX_S = 18'h000FF;
   localparam logic [17:0] EMAX_D = 18'h007FF;
   localparam logic [17:0] BIAS_S = 18'h0007F;
   localparam logic [17:0] BIAS_D = 18'h003FF;
   localparam logic [17:0] BIAS_X = 18'h03FFF;
   localparam logic [14:0] XS_OFS = 15'h3F80;
   localparam logic [14:0] XD_OFS = 15'h3C00;
   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0] id;
      logic [3:0] op;
      logic s1_mem;
      logic [1:0] s1_fmt;
      logic [2:0] s1_reg;
      logic s2_mem;
      logic [1:0] s2_fmt;
      logic [2:0] s2_reg;
      logic d_mem;
      logic [1:0] d_fmt;
      logic [2:0] d_reg;
      logic [5:0] unused;
   } fph_cmd_t;
   typedef struct packed {
      logic inv;
      logic unf;
      logic ovf;
      logic dz;
      logic inx;
   } fph_flags_t;
   typedef struct packed {
      logic [95:0] data;
      fph_flags_t fl;
   } fph_conv_t;
endpackage : fph_pkg

// >>> verilog/fph_fpreg_mem.sv
// Eight double-extended operand registers with a registered read port
module fph_fpreg_mem (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Write port
   input wire logic we_i,
   input wire logic [2:0] waddr_i,
   input wire logic [79:0] wdata_i,
   // Read port
   input wire logic [2:0] raddr_i,
   output logic [79:0] rdata_o
);
   logic [79:0] mem_ff [8];
   logic [79:0] rdata_ff;

   // Storage holds no reset; software loads registers before use
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_ff[waddr_i] <= wdata_i;
      end
   end

   // Read data always one cycle after the address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= mem_ff[raddr_i];
      end
   end
   assign rdata_o = rdata_ff;
endmodule : fph_fpreg_mem

// >>> verilog/fph_host.sv
// Host protocol sequencer of the floating-point coprocessor, both protocol modes
// Overview of operation
// RL1 - Broadcast command word kept only when its id field matches ours.
// RL2 - Collect exactly the needed operand fetch words into storage.
// RL3 - After executing, raise done and wait for a status fetch.
// RL4 - Status fetch: exception pending flags it and idles, else returns status.
// RL5 - Memory result driven one word per data write, then idle.
// RL6 - Peripheral registers memory mapped; every operation starts with a command write.
// RL7 - Command register write clears the result ready flag.
// RL8 - Operands come from the eight internal registers or the data port.
// RL9 - Master writes memory operands word by word after the command.
// RL10 - Master reads memory results word by word from the data port.
// RL11 - Completion updates condition codes and exception bits in aux status.
// RL12 - Completion sets result ready, raises interrupt, returns to idle.
// RL13 - All transfers use one 32-bit two-way data bus; the Wishbone port has separate 32-bit input and output data buses.
// RL14 - Single, double and double-extended formats are accepted.
// RL15 - Signed 32-bit integers accepted; packed decimal is refused as invalid.
// RL16 - Memory operands are widened to double-extended before use.
// RL17 - Results are rounded to nearest even into the destination format.
// RL18 - Mask and sticky bit for each of five exceptions.
// RL19 - Operation set is move, negate, absolute value and compare.
// RL20 - Reserved command bits should be written as zero.
// RL21 - Protocol mode strap caught during reset, fixed until next reset.
module fph_host (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Mode strap: high selects coprocessor protocol
   input wire logic cop_mode_i,
   // Wishbone register slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Coprocessor transaction port
   input wire logic cop_valid_i,
   input wire logic [1:0] cop_kind_i,
   input wire logic [31:0] cop_dat_i,
   output logic [31:0] cop_dat_o,
   output logic cop_dat_oe_o,
   output logic cop_ack_o,
   output logic cop_exc_o,
   output logic cop_done_o,
   // Interrupt request
   output logic periph_irq_out_o
);
   // ------------------------------------------------------------
   // Conversion helpers
   // ------------------------------------------------------------
   // RL14 - words per format
   function automatic logic [1:0] nwords(input logic [1:0] fmt);
      nwords = (fmt == fph_pkg::FMT_D) ? 2'h2 : (fmt == fph_pkg::FMT_X) ? 2'h3 : 2'h1;
   endfunction : nwords

   function automatic logic [79:0] to_ext(input logic [95:0] w, input logic [1:0] fmt);
      logic [79:0] r;
      logic [31:0] mag;
      logic [7:0] es;
      logic [10:0] ed;
      int pos;
      r = '0;
      pos = 0;
      mag = w[31] ? 32'(-w[31:0]) : w[31:0];
      es = (w[30:23] == 8'h00) ? 8'h01 : w[30:23];
      ed = (w[62:52] == 11'h000) ? 11'h001 : w[62:52];
      case (fmt)
         fph_pkg::FMT_S: begin
            if (w[30:23] == 8'hFF) begin
               r = {w[31], 15'h7FFF, 1'b1, w[22:0], 40'h0};
            end else if (w[30:0] != 31'h0) begin
               r = {w[31], 15'({7'h00, es}) + fph_pkg::XS_OFS, w[30:23] != 8'h00, w[22:0], 40'h0};
            end else begin
               r = {w[31], 79'h0};
            end
         end
         fph_pkg::FMT_D: begin
            if (w[62:52] == 11'h7FF) begin
               r = {w[63], 15'h7FFF, 1'b1, w[51:0], 11'h000};
            end else if (w[62:0] != 63'h0) begin
               r = {w[63], 15'({4'h0, ed}) + fph_pkg::XD_OFS, w[62:52] != 11'h000, w[51:0], 11'h000};
            end else begin
               r = {w[63], 79'h0};
            end
         end
         fph_pkg::FMT_X: begin
            r = w[79:0];
         end
         default: begin
            // Integer: normalise the magnitude behind the explicit bit
            for (int i = 0; i < 32; i++) begin
               if (mag[i]) begin
                  pos = i;
               end
            end
            if (mag != 32'h0) begin
               r = {w[31], fph_pkg::BIAS_X[14:0] + 15'(pos), {32'h0, mag} << 6'(63 - pos)};
            end
         end
      endcase
      to_ext = r;
   endfunction : to_ext

   function automatic fph_pkg::fph_conv_t to_fmt(input logic [79:0] x, input logic [1:0] fmt);
      fph_pkg::fph_conv_t r;
      logic [5:0] fw;
      logic [17:0] e;
      logic [17:0] emax;
      logic [63:0] m;
      logic [52:0] f;
      logic g;
      logic st;
      r = '0;
      fw = (fmt == fph_pkg::FMT_D) ? fph_pkg::FW_D : fph_pkg::FW_S;
      emax = (fmt == fph_pkg::FMT_D) ? fph_pkg::EMAX_D : fph_pkg::EMAX_S;
      e = {3'h0, x[78:64]} - fph_pkg::BIAS_X + ((fmt == fph_pkg::FMT_D) ? fph_pkg::BIAS_D : fph_pkg::BIAS_S);
      m = {x[62:0], 1'b0};
      f = 53'(m >> (7'h40 - {1'b0, fw}));
      g = m[6'h3F - fw];
      st = |(m << (fw + 6'h01));
      // Round to nearest, ties to even; a carry out bumps the exponent
      f = f + 53'(g & (st | f[0]));
      if (f[fw]) begin
         f = '0;
         e = e + 18'h00001;
      end
      if (x[78:64] == 15'h7FFF) begin
         e = emax;
         f = (x[62:0] != 63'h0) ? '1 : '0;
      end else if (x[78:0] == 79'h0) begin
         e = '0;
         f = '0;
      end else if (e[17] || e == 18'h00000) begin
         // Flush to zero: no denormal results are produced
         r.fl.unf = 1'b1;
         r.fl.inx = 1'b1;
         e = '0;
         f = '0;
      end else if (e >= emax) begin
         r.fl.ovf = 1'b1;
         r.fl.inx = 1'b1;
         e = emax;
         f = '0;
      end else begin
         r.fl.inx = g | st;
      end
      case (fmt)
         fph_pkg::FMT_S: r.data = {x[79], e[7:0], f[22:0], 64'h0};
         fph_pkg::FMT_D: r.data = {x[79], e[10:0], f[51:0], 32'h0};
         fph_pkg::FMT_X: r.data = {16'h0000, x};
         default: r.fl.inv = 1'b1;
      endcase
      to_fmt = r;
   endfunction : to_fmt

   function automatic logic [79:0] okey(input logic [79:0] x);
      okey = x[79] ? ~x : {1'b1, x[78:0]};
   endfunction : okey

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_FETCH, ST_RDA, ST_RDB, ST_RDW, ST_EXEC, ST_WAIT, ST_STORE
   } fph_state_t;
   fph_state_t state_ff, nxt_state;
   fph_pkg::fph_cmd_t cmd_ff;
   logic mode_ff;
   logic fidx_ff;
   logic [1:0] wcnt_ff;
   logic [95:0] a_ff, b_ff, out_ff;
   logic [1:0] ocnt_ff;
   logic [4:0] mask_ff, stk_ff;
   logic [2:0] cc_ff;
   logic ra_ff, exc_ff, irq_ff;
   logic [31:0] wb_dat_ff, cop_dat_ff;
   logic wb_ack_ff, cop_ack_ff, cop_oe_ff, cop_exc_ff, cop_done_ff;
   logic [79:0] rdata;

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   wire wb_go = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
   wire wb_wr = wb_go & wb_we_i & (wb_sel_i == 4'hF);
   wire wb_rd = wb_go & ~wb_we_i;
   wire cop_take = mode_ff & cop_valid_i & ~cop_ack_ff;
   wire idle = (state_ff == ST_IDLE);
   fph_pkg::fph_cmd_t cmd_in;
   assign cmd_in = mode_ff ? cop_dat_i : wb_dat_i;
   // RL1 - id compare at broadcast
   wire cop_cmd = cop_take & (cop_kind_i == fph_pkg::KIND_BCAST) & (cop_dat_i[31:28] == fph_pkg::OWN_ID);
   // RL6 - command write starts an operation
   wire per_cmd = ~mode_ff & wb_wr & (wb_adr_i == fph_pkg::ADR_CMD);
   wire cmd_go = idle & (cop_cmd | per_cmd);
   wire cop_fetch = cop_take & (cop_kind_i == fph_pkg::KIND_FETCH) & (state_ff == ST_FETCH);
   wire cop_stat = cop_take & (cop_kind_i == fph_pkg::KIND_STAT) & (state_ff == ST_WAIT);
   wire cop_wr = cop_take & (cop_kind_i == fph_pkg::KIND_WRITE) & (state_ff == ST_STORE);
   wire cop_go = cop_take & ((cop_kind_i == fph_pkg::KIND_BCAST) | cop_fetch | cop_stat | cop_wr);
   // RL9 - data port writes count only while fetching
   wire per_word = ~mode_ff & wb_wr & (wb_adr_i == fph_pkg::ADR_DATA) & (state_ff == ST_FETCH);
   wire word_stb = cop_fetch | per_word;
   wire [31:0] word_val = mode_ff ? cop_dat_i : wb_dat_i;
   // RL10 - data port read pops one result word
   wire per_pop = ~mode_ff & wb_rd & (wb_adr_i == fph_pkg::ADR_DATA) & (ocnt_ff != 2'h0);
   wire need_a = cmd_in.s1_mem;
   wire need_b = cmd_in.s2_mem & (cmd_in.op == fph_pkg::OP_CMP);
   wire last_w = (wcnt_ff == 2'h1);
   wire more_b = ~fidx_ff & cmd_ff.s2_mem & (cmd_ff.op == fph_pkg::OP_CMP);

   // ------------------------------------------------------------
   // Execution datapath
   // ------------------------------------------------------------
   logic [79:0] a_x, b_x, res_x;
   fph_pkg::fph_conv_t conv;
   fph_pkg::fph_flags_t fl;
   logic [2:0] cc_new;
   // RL16 - memory operands widened to extended
   assign a_x = cmd_ff.s1_mem ? to_ext(a_ff, cmd_ff.s1_fmt) : a_ff[79:0];
   assign b_x = cmd_ff.s2_mem ? to_ext(b_ff, cmd_ff.s2_fmt) : b_ff[79:0];
   // RL19 - sign operations and compare
   assign res_x = (cmd_ff.op == fph_pkg::OP_NEG) ? {~a_x[79], a_x[78:0]} :
                  (cmd_ff.op == fph_pkg::OP_ABS) ? {1'b0, a_x[78:0]} : a_x;
   // RL17 - round into the destination format
   assign conv = to_fmt(res_x, cmd_ff.d_fmt);
   wire a_nan = (a_x[78:64] == 15'h7FFF) & (a_x[62:0] != 63'h0);
   wire b_nan = (b_x[78:64] == 15'h7FFF) & (b_x[62:0] != 63'h0);
   wire is_cmp = (cmd_ff.op == fph_pkg::OP_CMP);
   wire both_z = (a_x[78:0] == 79'h0) & (b_x[78:0] == 79'h0);
   wire bad_op = (cmd_ff.op > fph_pkg::OP_CMP);
   // RL15 - packed decimal has no encoding and is refused
   always_comb begin
      fl = cmd_ff.d_mem & ~is_cmp ? conv.fl : '0;
      fl.inv = fl.inv | bad_op | (is_cmp & (a_nan | b_nan));
      if (is_cmp) begin
         cc_new = {okey(b_x) < okey(a_x), (a_x == b_x) | both_z, a_nan | b_nan};
      end else begin
         cc_new = {res_x[79], res_x[78:0] == 79'h0, (res_x[78:64] == 15'h7FFF) & (res_x[62:0] != 63'h0)};
      end
   end
   wire exc_new = |(fl & ~mask_ff);
   wire reg_we = (state_ff == ST_EXEC) & ~cmd_ff.d_mem & ~is_cmp & ~bad_op;
   wire [2:0] raddr = (state_ff == ST_RDA) ? cmd_ff.s1_reg : cmd_ff.s2_reg;
   wire [31:0] aux_word = {15'h0000, mode_ff, cc_ff, mask_ff, stk_ff, exc_ff, ~idle, ra_ff};

   // RL8 - eight internal operand registers
   fph_fpreg_mem u_regs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(reg_we),
      .waddr_i(cmd_ff.d_reg),
      .wdata_i(res_x),
      .raddr_i(raddr),
      .rdata_o(rdata)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: if (cmd_go) nxt_state = (need_a | need_b) ? ST_FETCH : ST_RDA;
         // RL2 - exact word count per operand
         ST_FETCH: if (word_stb & last_w & ~more_b) nxt_state = ST_RDA;
         ST_RDA: nxt_state = ST_RDB;
         ST_RDB: nxt_state = ST_RDW;
         ST_RDW: nxt_state = ST_EXEC;
         // RL12 - peripheral mode goes quiescent at once
         ST_EXEC: nxt_state = mode_ff ? ST_WAIT : ST_IDLE;
         // RL4 - exception drops the result
         ST_WAIT: if (cop_stat) nxt_state = (~exc_ff & cmd_ff.d_mem & ~is_cmp) ? ST_STORE : ST_IDLE;
         // RL5 - idle after the last word
         ST_STORE: if (cop_wr & (ocnt_ff == 2'h1)) nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   // RL21 - strap caught while reset is held
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_ff <= cop_mode_i;
      end
   end

   // Command, fetch counting and operand assembly, most significant word first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         cmd_ff <= '0;
         fidx_ff <= 1'b0;
         wcnt_ff <= 2'h0;
         a_ff <= '0;
         b_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         if (cmd_go) begin
            cmd_ff <= cmd_in;
            fidx_ff <= ~need_a;
            wcnt_ff <= need_a ? nwords(cmd_in.s1_fmt) : nwords(cmd_in.s2_fmt);
         end else if (word_stb) begin
            if (fidx_ff) b_ff <= {b_ff[63:0], word_val};
            else a_ff <= {a_ff[63:0], word_val};
            if (last_w & more_b) begin
               fidx_ff <= 1'b1;
               wcnt_ff <= nwords(cmd_ff.s2_fmt);
            end else begin
               wcnt_ff <= wcnt_ff - 2'h1;
            end
         end
         if (state_ff == ST_RDB && !cmd_ff.s1_mem) a_ff <= {16'h0000, rdata};
         if (state_ff == ST_RDW && !cmd_ff.s2_mem) b_ff <= {16'h0000, rdata};
      end
   end

   // Result buffer: left aligned, shifted one word per transfer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_ff <= '0;
         ocnt_ff <= 2'h0;
      end else if (state_ff == ST_EXEC) begin
         out_ff <= conv.data;
         ocnt_ff <= (cmd_ff.d_mem & ~is_cmp & ~bad_op) ? nwords(cmd_ff.d_fmt) : 2'h0;
      end else if (cop_wr | per_pop) begin
         out_ff <= {out_ff[63:0], 32'h0};
         ocnt_ff <= ocnt_ff - 2'h1;
      end
   end

   // Status: sticky set wins over a write-one clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_ff <= fph_pkg::MASK_RST;
         stk_ff <= '0;
         cc_ff <= '0;
         ra_ff <= 1'b0;
         exc_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         if (wb_wr && wb_adr_i == fph_pkg::ADR_AUX) begin
            // RL18 - mask bits written, sticky bits cleared by one
            mask_ff <= wb_dat_i[fph_pkg::AUX_MSK +: 5];
            stk_ff <= (stk_ff & ~wb_dat_i[fph_pkg::AUX_STK +: 5]) | ((state_ff == ST_EXEC) ? fl : 5'h00);
         end else if (state_ff == ST_EXEC) begin
            stk_ff <= stk_ff | fl;
         end
         if (state_ff == ST_EXEC) begin
            // RL11 - condition codes and exception update
            cc_ff <= cc_new;
            exc_ff <= exc_new;
            // RL12 - result ready and interrupt
            ra_ff <= ~mode_ff;
            irq_ff <= ~mode_ff;
         end else if (cmd_go) begin
            // RL7 - command write clears result ready
            ra_ff <= 1'b0;
            irq_ff <= 1'b0;
         end
      end
   end

   // Bus answers: one-cycle acknowledge, registered read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_ff <= 1'b0;
         wb_dat_ff <= '0;
         cop_ack_ff <= 1'b0;
         cop_dat_ff <= '0;
         cop_oe_ff <= 1'b0;
         cop_exc_ff <= 1'b0;
         cop_done_ff <= 1'b0;
      end else begin
         wb_ack_ff <= wb_go;
         if (wb_rd) begin
            wb_dat_ff <= (wb_adr_i == fph_pkg::ADR_CMD) ? cmd_ff :
                         (wb_adr_i == fph_pkg::ADR_AUX) ? aux_word :
                         (per_pop) ? out_ff[95:64] : 32'h0;
         end
         cop_ack_ff <= cop_go;
         // RL13 - drive the shared data bus only on status fetches and data writes
         cop_oe_ff <= cop_stat | cop_wr;
         // RL4 - exception flagged at status fetch
         cop_exc_ff <= cop_stat & exc_ff;
         if (cop_stat) cop_dat_ff <= aux_word;
         else if (cop_wr) cop_dat_ff <= out_ff[95:64];
         // RL3 - done shown while waiting for status
         cop_done_ff <= (nxt_state == ST_WAIT);
      end
   end

   assign wb_ack_o = wb_ack_ff;
   assign wb_dat_o = wb_dat_ff;
   assign cop_ack_o = cop_ack_ff;
   assign cop_dat_o = cop_dat_ff;
   assign cop_dat_oe_o = cop_oe_ff;
   assign cop_exc_o = cop_exc_ff;
   assign cop_done_o = cop_done_ff;
   assign periph_irq_out_o = irq_ff;
endmodule : fph_host

// >>> tb/fph_host_chk.sv
// Port checker of the coprocessor host sequencer
module fph_host_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_ack_o,
   // Coprocessor port
   input wire logic cop_valid_i,
   input wire logic [1:0] cop_kind_i,
   input wire logic cop_dat_oe_o,
   input wire logic cop_ack_o,
   input wire logic cop_exc_o,
   input wire logic cop_done_o,
   // Interrupt
   input wire logic periph_irq_out_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Accepted command write and answered status fetch
   sequence s_cmd_wr;
      wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == fph_pkg::ADR_CMD && wb_sel_i == 4'hF;
   endsequence
   sequence s_stat;
      cop_ack_o && cop_kind_i == fph_pkg::KIND_STAT;
   endsequence
   property p_wb_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_wb_ack: assert property (p_wb_ack) else $error("bus ack late");
   property p_wb_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_wb_pulse: assert property (p_wb_pulse) else $error("bus ack too long");
   property p_bcast; cop_valid_i && !cop_ack_o && cop_kind_i == fph_pkg::KIND_BCAST |=> cop_ack_o; endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast not answered");
   property p_cop_pulse; cop_ack_o |=> !cop_ack_o; endproperty
   a_cop_pulse: assert property (p_cop_pulse) else $error("cop ack too long");
   property p_done_hold; cop_done_o && !(cop_valid_i && cop_kind_i == fph_pkg::KIND_STAT) |=> cop_done_o; endproperty
   a_done_hold: assert property (p_done_hold) else $error("done dropped early");
   property p_stat_done; s_stat |-> !cop_done_o && $past(cop_done_o); endproperty
   a_stat_done: assert property (p_stat_done) else $error("status fetch without done");
   property p_exc; cop_exc_o |-> cop_ack_o && cop_kind_i == fph_pkg::KIND_STAT; endproperty
   a_exc: assert property (p_exc) else $error("stray exception");
   property p_oe; cop_dat_oe_o |-> cop_ack_o && cop_kind_i[1]; endproperty
   a_oe: assert property (p_oe) else $error("bus driven outside answer");
   property p_irq_clr; periph_irq_out_o ##0 s_cmd_wr |=> !periph_irq_out_o; endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("irq kept after command");
   property p_irq_fall; $fell(periph_irq_out_o) |-> $past(wb_cyc_i && wb_we_i && wb_adr_i == fph_pkg::ADR_CMD); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without command");
endmodule : fph_host_chk
bind fph_host fph_host_chk chk_u (.*);

// >>> tb/fph_cop_cpu.sv
// Host CPU model issuing coprocessor transactions
module fph_cop_cpu (
   // Clock and answers
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic exc_i,
   input wire logic [31:0] rdat_i,
   // Requests
   output logic vld_o = 1'h0,
   output logic [1:0] kind_o = 2'h0,
   output logic [31:0] dat_o = 32'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   // request held until ack; released bus shows the inverse word
   task automatic xfer(input logic [1:0] k, input logic [31:0] d, input int gap, output logic [31:0] q,
                       output logic e);
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      vld_o <= 1'h1;
      kind_o <= k;
      dat_o <= d;
      do @(posedge clk_i); while (ack_i !== 1'h1);
      q = rdat_i;
      e = exc_i;
      vld_o <= 1'h0;
      dat_o <= ~d;
   endtask : xfer
endmodule : fph_cop_cpu

// >>> tb/fph_host_bench.sv
// Self-checking bench of the host sequencer in both protocol modes
module fph_host_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic cop_mode_i = 1'h0;
   logic wb_cyc_i = 1'h0;
   logic wb_stb_i = 1'h0;
   logic wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, cop_dat_i, cop_dat_o, q;
   logic wb_ack_o, cop_valid_i, cop_dat_oe_o, cop_ack_o, cop_exc_o, cop_done_o, periph_irq_out_o, e;
   logic [1:0] cop_kind_i;
   int fails = 0;
   int samples_checked = 0;
   fph_host dut_u (.*);
   fph_cop_cpu cpu_u (.clk_i(clk_i), .ack_i(cop_ack_o), .exc_i(cop_exc_o), .rdat_i(cop_dat_o),
                      .vld_o(cop_valid_i), .kind_o(cop_kind_i), .dat_o(cop_dat_i));
   // 40 MHz clock
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("compares %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test
   // Mode strap is only caught while reset is held
   task automatic rst_run(input logic m);
      @(posedge clk_i);
      rst_i <= 1'h1;
      cop_mode_i <= m;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
   endtask : rst_run
   // Classic single Wishbone cycle, request held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'h1);
      r = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask : wb
   // One peripheral operation: command, operand words, wait for result, read words
   task automatic pop(input logic [31:0] cmd, input int nw, input logic [63:0] opd, input int nr,
                      input logic [63:0] res, input logic [31:0] aux);
      logic [31:0] r;
      wb(1'h1, fph_pkg::ADR_CMD, cmd, r);
      wb(1'h0, fph_pkg::ADR_AUX, 32'h0, r);
      chk({30'h0, r[0], periph_irq_out_o}, 32'h0);
      for (int i = 0; i < nw; i++) wb(1'h1, fph_pkg::ADR_DATA, opd[63 - 32 * i -: 32], r);
      do wb(1'h0, fph_pkg::ADR_AUX, 32'h0, r); while (r[0] !== 1'h1);
      chk(r, aux);
      chk({31'h0, periph_irq_out_o}, 32'h1);
      for (int i = 0; i < nr; i++) begin
         wb(1'h0, fph_pkg::ADR_DATA, 32'h0, r);
         chk(r, res[63 - 32 * i -: 32]);
      end
      $display("operation %h done", cmd);
   endtask : pop
   // Main sequence; reserved command bits are written as zero
   initial begin
      rst_run(1'h0);
      pop(32'h5080_0800, 1, 64'h3F80_0000_0000_0000, 1, 64'h3F80_0000_0000_0000, 32'h1);
      pop(32'h5180_0800, 1, 64'h3F80_0000_0000_0000, 1, 64'hBF80_0000_0000_0000, 32'h8001);
      pop(32'h5280_0800, 1, 64'hC000_0000_0000_0000, 1, 64'h4000_0000_0000_0000, 32'h1);
      pop(32'h50E0_0800, 1, 64'h0000_0005_0000_0000, 1, 64'h40A0_0000_0000_0000, 32'h1);
      pop(32'h50A0_0800, 2, 64'h3FF0_0000_0000_0000, 1, 64'h3F80_0000_0000_0000, 32'h1);
      pop(32'h5080_0A00, 1, 64'h3F80_0000_0000_0000, 2, 64'h3FF0_0000_0000_0000, 32'h1);
      pop(32'h5080_00C0, 1, 64'h4040_0000_0000_0000, 0, 64'h0, 32'h1);
      pop(32'h500C_0800, 0, 64'h0, 1, 64'h4040_0000_0000_0000, 32'h1);
      pop(32'h5382_0000, 2, 64'h4000_0000_3F80_0000, 0, 64'h0, 32'h8001);
      wb(1'h0, 8'h0C, 32'h0, q);
      chk(q, 32'h0);
      rst_run(1'h1);
      cpu_u.xfer(fph_pkg::KIND_BCAST, 32'h3180_0800, 0, q, e);
      cpu_u.xfer(fph_pkg::KIND_BCAST, 32'h5080_0800, 3, q, e);
      cpu_u.xfer(fph_pkg::KIND_FETCH, 32'h4000_0000, 0, q, e);
      cpu_u.xfer(fph_pkg::KIND_STAT, 32'h0, 6, q, e);
      chk({15'h0, q[16], 15'h0, e}, 32'h0001_0000);
      cpu_u.xfer(fph_pkg::KIND_WRITE, 32'h0, 0, q, e);
      chk(q, 32'h4000_0000);
      cpu_u.xfer(fph_pkg::KIND_BCAST, 32'h5080_0E00, 0, q, e);
      cpu_u.xfer(fph_pkg::KIND_FETCH, 32'h3F80_0000, 0, q, e);
      cpu_u.xfer(fph_pkg::KIND_STAT, 32'h0, 0, q, e);
      chk({31'h0, e}, 32'h1);
      $display("coprocessor tests done");
      finish_test;
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (4000) @(posedge clk_i);
      fails++;
      $display("BAD t=%0t run hung", $time);
      finish_test;
   end
endmodule : fph_host_bench
